// ### bfl_defs.svh
// Constants of the boot and flash image loader: flash map, command, address
// layout and timing counts.
// Assumes a core clock whose rate is given by BFL_CLK_MHZ.
`ifndef BFL_DEFS_SVH
`define BFL_DEFS_SVH

// ****************************************************************
// Flash map
// ****************************************************************
`define BFL_HDR_LOW_ADDR      24'h000000
`define BFL_HDR_HIGH_ADDR     24'h001000
`define BFL_HDR_BLOCK_BYTES   24'h001000
`define BFL_FLASH_BYTES       32'h00100000
`define BFL_READ_CMD          8'h03
`define BFL_XFER_BITS         7'h60
`define BFL_ERASED_WORD       32'hFFFFFFFF

// ****************************************************************
// Target address byte
// ****************************************************************
`define BFL_ADDR_FIXED        8'h4E
`define BFL_ADDR_STRAP_B_BIT  5
`define BFL_ADDR_STRAP_A_BIT  4
`define BFL_ADDR_RST          8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define BFL_CLK_MHZ           40
`define BFL_TRIM_SETTLE_NS    2000
`define BFL_TRIM_SETTLE_CYC   ((`BFL_TRIM_SETTLE_NS * `BFL_CLK_MHZ + 999) / 1000)
`define BFL_PERSIST_NS        20000
`define BFL_PERSIST_CYC       ((`BFL_PERSIST_NS * `BFL_CLK_MHZ + 999) / 1000)
`define BFL_SPI_HALF_CYC      4

`endif

// ### bfl_flash_model.sv
// Behavioural SPI flash that answers the read command in mode 0.
// Assumes the loader drives clock, data out and the active-low select.
`timescale 1ns/10ps
module bfl_flash_model (
  // SPI pins
  input  wire logic i_sclk,
  input  wire logic i_mosi,
  input  wire logic i_sel_n,
  output logic      o_miso
);
  // ****************************************************************
  // Storage and shifter
  // ****************************************************************
  logic [7:0]  mem [int];
  logic [31:0] cmd_addr;
  logic [7:0]  b;
  int          nbit;
  int          d;

  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  initial
  begin
    o_miso = 1'b0;
    nbit = 0;
    cmd_addr = 32'h0;
  end

  always @(negedge i_sel_n)
  begin
    nbit = 0;
  end

  always @(posedge i_sclk)
  begin
    if (!i_sel_n && nbit < 32)
      cmd_addr = {cmd_addr[30:0], i_mosi};
    if (!i_sel_n)
      nbit = nbit + 1;
  end

  always @(negedge i_sclk or posedge i_sel_n)
  begin
    d = nbit - 32;
    b = rd(int'(cmd_addr[23:0]) + d / 8);
    if (i_sel_n)
      o_miso <= ~o_miso;
    else if (d >= 0 && d < 64)
      o_miso <= b[7 - d % 8];
  end
endmodule

// ### bfl_loader.sv
// Boot sequencer and SPI flash image loader.
// Assumes asynchronous pins, a mode 0 SPI flash and an OTP fetch handshake.
//
// How it works
// - Rail monitor holds internal reset; leaving it pulses a boot interrupt.
// - OTP boot code is fetched first, before anything else proceeds.
// - Registers reset, trims load, trims settle, then clock, persistence and peripherals come up before the address is configured.
// - Target address comes from the two synchronized strap pins.
// - Address byte is 0,1,strap b,strap a,1,1,1 and the read/write bit.
// - Limited host interface is enabled once the address is set.
// - Dead battery means main supply invalid while VBUS valid.
// - In dead battery the path select pin is sampled, power path configured.
// - 48 MHz clock enabled; persistence counter waits for stable supplies.
// - Thermal blocks enabled first, then converter, CRC, GPIO, interrupts.
// - Low header at 0x000000, high header at 0x001000, 4 kB each.
// - Firmware address is region pointer plus application offset.
// - Two regions so a failed update leaves the old image bootable.
// - Low region tried first; any invalid data switches to high region.
// - Both regions invalid leads to invalid-memory handling.
// - Invalid memory presents the debug port on the SBU pins.
// - SPI mode 0: clock idles low, launch on fall; flash samples on rise, loader captures MISO at the fall.
// - Chip select active low; first bit driven as select goes low.
`timescale 1ns/10ps
`include "bfl_defs.svh"
module bfl_loader #(
  parameter logic [31:0] FLASH_BYTES = `BFL_FLASH_BYTES,
  parameter int unsigned SPI_HALF    = `BFL_SPI_HALF_CYC,
  parameter int unsigned SETTLE_CYC  = `BFL_TRIM_SETTLE_CYC,
  parameter int unsigned PERSIST_CYC = `BFL_PERSIST_CYC
) (
  // Clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_srst,
  // Supply and strap pins
  input  wire logic            i_internal_3v3_rail,
  input  wire logic            i_main_3v3_supply,
  input  wire logic            i_vbus_valid,
  input  wire logic            i_addr_strap_a,
  input  wire logic            i_addr_strap_b,
  input  wire logic            i_dead_battery_path_select,
  // OTP fetch
  input  wire logic            i_otp_done,
  output logic                 o_otp_fetch,
  // Boot control
  output logic                 o_core_reset,
  output logic                 o_boot_irq,
  output logic                 o_regs_rst,
  output logic                 o_trim_load,
  output logic                 o_clk48_en,
  output bfl_pkg::bfl_en_t     o_en,
  // Host interface
  output logic [7:0]           o_i2c_addr_byte,
  output logic                 o_host_lim_en,
  // Power path
  output logic                 o_dead_battery,
  output logic                 o_pp_cfg_en,
  output logic                 o_pp_sel,
  // SPI flash
  input  wire logic            i_spi_miso,
  output logic                 o_spi_clk,
  output logic                 o_spi_mosi,
  output logic                 o_flash_select_n,
  // Image result
  output logic                 o_app_valid,
  output logic                 o_app_high,
  output logic [23:0]          o_app_addr,
  output logic                 o_swd_on_sbu
);

  // ****************************************************************
  // Pin synchronizers
  // ****************************************************************
  logic [6:0] pins_s;
  logic       rail_s;
  logic       main_s;
  logic       vbus_s;
  logic       strap_a_s;
  logic       strap_b_s;
  logic       path_s;
  logic       miso_s;

  bfl_sync #(.W(7)) u_sync (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_d    ({i_internal_3v3_rail, i_main_3v3_supply, i_vbus_valid, i_addr_strap_a,
              i_addr_strap_b, i_dead_battery_path_select, i_spi_miso}),
    .o_q    (pins_s)
  );

  assign {rail_s, main_s, vbus_s, strap_a_s, strap_b_s, path_s, miso_s} = pins_s;

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  bfl_pkg::bfl_state_t st_q, st_d;
  bfl_pkg::bfl_en_t    en_q, en_d;
  bfl_pkg::bfl_hdr_t   hdr;
  logic [15:0]         cnt_q, cnt_d;
  logic [1:0]          sup_q, sup_d;
  logic [7:0]          addr_q, addr_d;
  logic [23:0]         app_q, app_d;
  logic [32:0]         sum;
  logic                hdr_ok;
  logic                core_rst_q, core_rst_d;
  logic                irq_q, irq_d;
  logic                otp_q, otp_d;
  logic                rrst_q, rrst_d;
  logic                trim_q, trim_d;
  logic                clk48_q, clk48_d;
  logic                host_q, host_d;
  logic                db_q, db_d;
  logic                ppc_q, ppc_d;
  logic                pps_q, pps_d;
  logic                hi_q, hi_d;
  logic                ok_q, ok_d;
  logic                swd_q, swd_d;
  logic                spi_go;
  logic [23:0]         go_addr;
  logic                spi_done_q;
  logic [63:0]         rx_q;

  assign hdr    = rx_q;
  assign sum    = {1'b0, hdr.region_pointer} + {1'b0, hdr.app_code_offset};
  assign hdr_ok = (hdr.region_pointer != `BFL_ERASED_WORD)
                && (hdr.app_code_offset != `BFL_ERASED_WORD)
                && (sum < {1'b0, FLASH_BYTES});

  always_comb
  begin
    st_d       = st_q;
    en_d       = en_q;
    cnt_d      = cnt_q;
    sup_d      = {vbus_s, main_s};
    addr_d     = addr_q;
    app_d      = app_q;
    core_rst_d = core_rst_q;
    irq_d      = 1'b0;
    otp_d      = otp_q;
    rrst_d     = 1'b0;
    trim_d     = 1'b0;
    clk48_d    = clk48_q;
    host_d     = host_q;
    db_d       = db_q;
    ppc_d      = ppc_q;
    pps_d      = pps_q;
    hi_d       = hi_q;
    ok_d       = ok_q;
    swd_d      = swd_q;
    spi_go     = 1'b0;
    go_addr    = `BFL_HDR_LOW_ADDR;
    unique case (st_q)
      bfl_pkg::BFL_POR:
      begin
        core_rst_d = 1'b1;
        if (rail_s)
        begin
          core_rst_d = 1'b0;
          irq_d      = 1'b1;
          otp_d      = 1'b1;
          st_d       = bfl_pkg::BFL_OTP;
        end
      end
      bfl_pkg::BFL_OTP:
      begin
        if (i_otp_done)
        begin
          otp_d  = 1'b0;
          rrst_d = 1'b1;
          st_d   = bfl_pkg::BFL_REGRST;
        end
      end
      bfl_pkg::BFL_REGRST:
      begin
        trim_d = 1'b1;
        st_d   = bfl_pkg::BFL_TRIM;
      end
      bfl_pkg::BFL_TRIM:
      begin
        cnt_d = 16'h0000;
        st_d  = bfl_pkg::BFL_SETTLE;
      end
      bfl_pkg::BFL_SETTLE:
      begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == 16'(SETTLE_CYC - 1))
        begin
          cnt_d   = 16'h0000;
          clk48_d = 1'b1;
          st_d    = bfl_pkg::BFL_PERSIST;
        end
      end
      bfl_pkg::BFL_PERSIST:
      begin
        if ((sup_d != sup_q) || (sup_d == 2'h0))
          cnt_d = 16'h0000;
        else if (cnt_q == 16'(PERSIST_CYC - 1))
        begin
          cnt_d    = 16'h0000;
          en_d.therm = 1'b1;
          st_d     = bfl_pkg::BFL_PERIPH;
        end
        else
          cnt_d = cnt_q + 16'h0001;
      end
      bfl_pkg::BFL_PERIPH:
      begin
        en_d.adc  = 1'b1;
        en_d.crc  = 1'b1;
        en_d.gpio = 1'b1;
        en_d.intc = 1'b1;
        st_d      = bfl_pkg::BFL_I2C;
      end
      bfl_pkg::BFL_I2C:
      begin
        addr_d = `BFL_ADDR_FIXED;
        addr_d[`BFL_ADDR_STRAP_B_BIT] = strap_b_s;
        addr_d[`BFL_ADDR_STRAP_A_BIT] = strap_a_s;
        st_d   = bfl_pkg::BFL_DBCHK;
      end
      bfl_pkg::BFL_DBCHK:
      begin
        host_d = 1'b1;
        db_d   = !main_s && vbus_s;
        if (db_d)
          st_d = bfl_pkg::BFL_DBPATH;
        else
        begin
          spi_go = 1'b1;
          st_d   = bfl_pkg::BFL_HDR;
        end
      end
      bfl_pkg::BFL_DBPATH:
      begin
        pps_d  = path_s;
        ppc_d  = 1'b1;
        spi_go = 1'b1;
        st_d   = bfl_pkg::BFL_HDR;
      end
      bfl_pkg::BFL_HDR, bfl_pkg::BFL_APP:
      begin
        if (spi_done_q)
        begin
          if ((st_q == bfl_pkg::BFL_HDR) && hdr_ok)
          begin
            app_d   = sum[23:0];
            go_addr = sum[23:0];
            spi_go  = 1'b1;
            st_d    = bfl_pkg::BFL_APP;
          end
          else if ((st_q == bfl_pkg::BFL_APP) && (hdr.region_pointer != `BFL_ERASED_WORD))
          begin
            ok_d = 1'b1;
            st_d = bfl_pkg::BFL_RUN;
          end
          else if (!hi_q)
          begin
            hi_d    = 1'b1;
            go_addr = `BFL_HDR_HIGH_ADDR;
            spi_go  = 1'b1;
            st_d    = bfl_pkg::BFL_HDR;
          end
          else
          begin
            swd_d = 1'b1;
            st_d  = bfl_pkg::BFL_INVALID;
          end
        end
      end
      bfl_pkg::BFL_RUN, bfl_pkg::BFL_INVALID:
      begin
        st_d = st_q;
      end
      default:
      begin
        st_d = bfl_pkg::BFL_POR;
      end
    endcase
    if (!rail_s)
    begin
      st_d       = bfl_pkg::BFL_POR;
      core_rst_d = 1'b1;
      irq_d      = 1'b0;
      en_d       = '0;
      otp_d      = 1'b0;
      clk48_d    = 1'b0;
      host_d     = 1'b0;
      db_d       = 1'b0;
      ppc_d      = 1'b0;
      hi_d       = 1'b0;
      ok_d       = 1'b0;
      swd_d      = 1'b0;
      spi_go     = 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_q       <= bfl_pkg::BFL_POR;
      en_q       <= '0;
      cnt_q      <= 16'h0000;
      sup_q      <= 2'h0;
      addr_q     <= `BFL_ADDR_RST;
      app_q      <= 24'h000000;
      core_rst_q <= 1'b1;
      irq_q      <= 1'b0;
      otp_q      <= 1'b0;
      rrst_q     <= 1'b0;
      trim_q     <= 1'b0;
      clk48_q    <= 1'b0;
      host_q     <= 1'b0;
      db_q       <= 1'b0;
      ppc_q      <= 1'b0;
      pps_q      <= 1'b0;
      hi_q       <= 1'b0;
      ok_q       <= 1'b0;
      swd_q      <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      en_q       <= en_d;
      cnt_q      <= cnt_d;
      sup_q      <= sup_d;
      addr_q     <= addr_d;
      app_q      <= app_d;
      core_rst_q <= core_rst_d;
      irq_q      <= irq_d;
      otp_q      <= otp_d;
      rrst_q     <= rrst_d;
      trim_q     <= trim_d;
      clk48_q    <= clk48_d;
      host_q     <= host_d;
      db_q       <= db_d;
      ppc_q      <= ppc_d;
      pps_q      <= pps_d;
      hi_q       <= hi_d;
      ok_q       <= ok_d;
      swd_q      <= swd_d;
    end
  end

  // ****************************************************************
  // SPI read engine
  // ****************************************************************
  logic        csn_q, csn_d;
  logic        sclk_q, sclk_d;
  logic        mosi_q, mosi_d;
  logic        spi_done_d;
  logic [7:0]  div_q, div_d;
  logic [6:0]  bit_q, bit_d;
  logic [31:0] tx_q, tx_d;
  logic [63:0] rx_d;

  always_comb
  begin
    csn_d      = csn_q;
    sclk_d     = sclk_q;
    mosi_d     = mosi_q;
    div_d      = div_q;
    bit_d      = bit_q;
    tx_d       = tx_q;
    rx_d       = rx_q;
    spi_done_d = 1'b0;
    if (spi_go)
    begin
      csn_d  = 1'b0;
      sclk_d = 1'b0;
      div_d  = 8'h00;
      bit_d  = 7'h00;
      mosi_d = 1'(`BFL_READ_CMD >> 7);
      tx_d   = {`BFL_READ_CMD, go_addr} << 1;
    end
    else if (!csn_q)
    begin
      if (div_q == 8'(SPI_HALF - 1))
      begin
        div_d = 8'h00;
        if (!sclk_q)
          sclk_d = 1'b1;
        else
        begin
          sclk_d = 1'b0;
          rx_d   = {rx_q[62:0], miso_s};
          if (bit_q == `BFL_XFER_BITS - 7'h01)
          begin
            csn_d      = 1'b1;
            mosi_d     = 1'b0;
            spi_done_d = 1'b1;
          end
          else
          begin
            bit_d  = bit_q + 7'h01;
            mosi_d = tx_q[31];
            tx_d   = {tx_q[30:0], 1'b0};
          end
        end
      end
      else
        div_d = div_q + 8'h01;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      csn_q      <= 1'b1;
      sclk_q     <= 1'b0;
      mosi_q     <= 1'b0;
      div_q      <= 8'h00;
      bit_q      <= 7'h00;
      tx_q       <= 32'h00000000;
      rx_q       <= 64'h0000000000000000;
      spi_done_q <= 1'b0;
    end
    else
    begin
      csn_q      <= csn_d;
      sclk_q     <= sclk_d;
      mosi_q     <= mosi_d;
      div_q      <= div_d;
      bit_q      <= bit_d;
      tx_q       <= tx_d;
      rx_q       <= rx_d;
      spi_done_q <= spi_done_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_otp_fetch      = otp_q;
  assign o_core_reset     = core_rst_q;
  assign o_boot_irq       = irq_q;
  assign o_regs_rst       = rrst_q;
  assign o_trim_load      = trim_q;
  assign o_clk48_en       = clk48_q;
  assign o_en             = en_q;
  assign o_i2c_addr_byte  = addr_q;
  assign o_host_lim_en    = host_q;
  assign o_dead_battery   = db_q;
  assign o_pp_cfg_en      = ppc_q;
  assign o_pp_sel         = pps_q;
  assign o_spi_clk        = sclk_q;
  assign o_spi_mosi       = mosi_q;
  assign o_flash_select_n = csn_q;
  assign o_app_valid      = ok_q;
  assign o_app_high       = hi_q;
  assign o_app_addr       = app_q;
  assign o_swd_on_sbu     = swd_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  property p_boot_irq;
    o_boot_irq |-> $past(o_core_reset) && !o_core_reset && o_otp_fetch;
  endproperty
  a_boot_irq: assert property (p_boot_irq) else $error("boot irq without reset release");

  property p_otp_first;
    $rose(o_regs_rst) |-> $past(o_otp_fetch) && !o_otp_fetch;
  endproperty
  a_otp_first: assert property (p_otp_first) else $error("regs reset before otp fetch");

  property p_trim_settle;
    o_trim_load |-> (st_q == bfl_pkg::BFL_TRIM) ##1 (st_q == bfl_pkg::BFL_SETTLE) [*2];
  endproperty
  a_trim_settle: assert property (p_trim_settle) else $error("trim settle skipped");

  property p_addr_form;
    o_host_lim_en |-> (o_i2c_addr_byte[7:6] == 2'h1) && (o_i2c_addr_byte[3:0] == 4'hE);
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("address byte malformed");

  property p_host_after_addr;
    $rose(o_host_lim_en) |-> $past(st_q == bfl_pkg::BFL_DBCHK) && $past(st_q, 2) == bfl_pkg::BFL_I2C;
  endproperty
  a_host_after_addr: assert property (p_host_after_addr) else $error("host on too early");

  property p_db_path;
    (st_q == bfl_pkg::BFL_HDR) && o_dead_battery |-> o_pp_cfg_en;
  endproperty
  a_db_path: assert property (p_db_path) else $error("flash read before power path");

  property p_persist;
    $rose(o_en.therm) |-> $past(cnt_q) == 16'(PERSIST_CYC - 1) && o_clk48_en;
  endproperty
  a_persist: assert property (p_persist) else $error("supplies not persisted");

  property p_periph_order;
    $rose(o_en.adc) |-> o_en.therm && $past(o_en.therm) && o_en.crc && o_en.intc;
  endproperty
  a_periph_order: assert property (p_periph_order) else $error("periph before thermal");

  property p_invalid;
    $rose(o_swd_on_sbu) |-> o_app_high && !o_app_valid && (st_q == bfl_pkg::BFL_INVALID);
  endproperty
  a_invalid: assert property (p_invalid) else $error("debug port without both regions");

  property p_cs_first_bit;
    $fell(o_flash_select_n) |-> !o_spi_clk && (o_spi_mosi == 1'(`BFL_READ_CMD >> 7));
  endproperty
  a_cs_first_bit: assert property (p_cs_first_bit) else $error("first bit not at select");

  property p_mode0;
    $changed(o_spi_mosi) && !o_flash_select_n |-> $fell(o_spi_clk) || $fell(o_flash_select_n);
  endproperty
  a_mode0: assert property (p_mode0) else $error("data launched off falling edge");

  property p_clk_idle;
    o_flash_select_n |-> !o_spi_clk;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock not idle low");

endmodule

// ### bfl_loader_tb_top.sv
// Self-checking bench of the boot sequencer and flash image loader.
// Assumes bfl_flash_model on the SPI pins and short settle counts.
`timescale 1ns/10ps
module bfl_loader_tb_top;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic            i_mclk = 1'b0;
  logic            i_srst = 1'b1;
  logic            rail = 1'b0;
  logic            mn = 1'b1;
  logic            vb = 1'b1;
  logic [1:0]      st = 2'h0;
  logic            ps = 1'b0;
  logic            i_otp_done = 1'b0;
  logic            miso;
  logic            o_otp_fetch, o_core_reset, o_boot_irq, o_regs_rst, o_trim_load;
  logic            o_clk48_en, o_host_lim_en, o_dead_battery, o_pp_cfg_en, o_pp_sel;
  logic            o_spi_clk, o_spi_mosi, o_flash_select_n;
  logic            o_app_valid, o_app_high, o_swd_on_sbu;
  logic [7:0]      o_i2c_addr_byte;
  logic [23:0]     o_app_addr;
  bfl_pkg::bfl_en_t o_en;
  int              err_count = 0;
  int              tests_run = 0;

  always #12.5 i_mclk = ~i_mclk;

  bfl_loader #(.SETTLE_CYC(2), .PERSIST_CYC(4)) i_bfl_loader (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_internal_3v3_rail(rail),
    .i_main_3v3_supply(mn), .i_vbus_valid(vb), .i_addr_strap_a(st[0]),
    .i_addr_strap_b(st[1]), .i_dead_battery_path_select(ps),
    .i_otp_done(i_otp_done), .o_otp_fetch(o_otp_fetch), .o_core_reset(o_core_reset),
    .o_boot_irq(o_boot_irq), .o_regs_rst(o_regs_rst), .o_trim_load(o_trim_load),
    .o_clk48_en(o_clk48_en), .o_en(o_en), .o_i2c_addr_byte(o_i2c_addr_byte),
    .o_host_lim_en(o_host_lim_en), .o_dead_battery(o_dead_battery),
    .o_pp_cfg_en(o_pp_cfg_en), .o_pp_sel(o_pp_sel), .i_spi_miso(miso),
    .o_spi_clk(o_spi_clk), .o_spi_mosi(o_spi_mosi), .o_flash_select_n(o_flash_select_n),
    .o_app_valid(o_app_valid), .o_app_high(o_app_high), .o_app_addr(o_app_addr),
    .o_swd_on_sbu(o_swd_on_sbu));

  bfl_flash_model i_bfl_flash_model (
    .i_sclk(o_spi_clk), .i_mosi(o_spi_mosi), .i_sel_n(o_flash_select_n), .o_miso(miso));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #2;
  endtask

  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      step(1);
      n++;
    end
    chk(s, 1'b1);
  endtask

  task automatic hdr(input int a, input logic [31:0] p, input logic [31:0] o);
    for (int i = 0; i < 4; i++)
    begin
      i_bfl_flash_model.mem[a + i] = p[31 - 8 * i -: 8];
      i_bfl_flash_model.mem[a + 4 + i] = o[31 - 8 * i -: 8];
    end
  endtask

  // SPI idle level and select timing
  always @(negedge o_flash_select_n)
  begin
    #1;
    chk(o_spi_clk, 1'b0);
    chk(o_spi_mosi, 1'b0);
  end

  // ****************************************************************
  // Boot run shared by every scenario
  // ****************************************************************
  task automatic boot(input logic [1:0] s, input logic m, input logic v, input logic p);
    i_srst = 1'b1;
    rail = 1'b0;
    st = s;
    mn = m;
    vb = v;
    ps = p;
    step(12);
    i_srst = 1'b0;
    step(3);
    chk(o_core_reset, 1'b1);
    chk(o_flash_select_n, 1'b1);
    rail = 1'b1;
    wait_hi(o_boot_irq, 10);
    chk(o_core_reset, 1'b0);
    chk(o_otp_fetch, 1'b1);
    step(3);
    chk(o_boot_irq, 1'b0);
    chk(o_regs_rst, 1'b0);
    i_otp_done = 1'b1;
    wait_hi(o_regs_rst, 5);
    i_otp_done = 1'b0;
    chk(o_trim_load, 1'b0);
    step(1);
    chk(o_trim_load, 1'b1);
    chk(o_i2c_addr_byte, 8'h00);
    wait_hi(o_clk48_en, 10);
    chk(o_en, 5'h00);
    for (int n = 0; n < 20 && o_en.therm !== 1'b1; n++)
      step(1);
    chk(o_en.therm, 1'b1);
    chk(o_en, 5'h10);
    step(1);
    chk(o_en, 5'h1F);
    wait_hi(o_host_lim_en, 10);
    chk(o_i2c_addr_byte, {2'b01, s, 4'hE});
    chk(o_dead_battery, !m && v);
    chk(o_pp_cfg_en, 1'b0);
    if (!m && v)
    begin
      wait_hi(o_pp_cfg_en, 5);
      chk(o_pp_sel, p);
    end
    for (int n = 0; n < 5000 && !(o_app_valid || o_swd_on_sbu); n++)
      step(1);
    chk(o_flash_select_n, 1'b1);
    chk(o_spi_clk, 1'b0);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_low;
    i_bfl_flash_model.mem.delete();
    hdr(0, 32'h2000, 32'h0100);
    hdr(32'h2100, 32'h12345678, 32'h0);
    hdr(32'h1000, 32'h8000, 32'h0);
    boot(2'h0, 1'b1, 1'b1, 1'b0);
    chk(o_app_valid, 1'b1);
    chk(o_app_high, 1'b0);
    chk(o_app_addr, 24'h002100);
    chk(i_bfl_flash_model.cmd_addr, 32'h03002100);
  endtask

  task automatic t_high;
    i_bfl_flash_model.mem.delete();
    hdr(32'h1000, 32'h40000, 32'h0200);
    hdr(32'h40200, 32'h00000001, 32'h0);
    boot(2'h1, 1'b1, 1'b0, 1'b0);
    chk(o_app_valid, 1'b1);
    chk(o_app_high, 1'b1);
    chk(o_app_addr, 24'h040200);
    chk(i_bfl_flash_model.cmd_addr, 32'h03040200);
  endtask

  task automatic t_bad;
    i_bfl_flash_model.mem.delete();
    hdr(0, 32'h000F0000, 32'h00010000);
    hdr(32'h1000, 32'h3000, 32'h0);
    boot(2'h2, 1'b1, 1'b1, 1'b0);
    chk(o_swd_on_sbu, 1'b1);
    chk(o_app_valid, 1'b0);
    chk(o_app_high, 1'b1);
  endtask

  task automatic t_dead;
    i_bfl_flash_model.mem.delete();
    hdr(0, 32'h2000, 32'h0);
    hdr(32'h2000, 32'h0000ABCD, 32'h0);
    boot(2'h3, 1'b0, 1'b1, 1'b1);
    chk(o_dead_battery, 1'b1);
    chk(o_app_valid, 1'b1);
    chk(o_app_addr, 24'h002000);
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence
  // ****************************************************************
  task automatic stop_test;
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge i_mclk);
    err_count++;
    stop_test();
  end

  initial
  begin
    t_low();
    t_high();
    t_bad();
    t_dead();
    stop_test();
  end
endmodule

// ### bfl_pkg.sv
// Types of the boot and flash image loader.
// Assumes bfl_defs.svh for all numeric constants.
package bfl_pkg;

  // ****************************************************************
  // Boot sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    BFL_POR     = 4'h0,
    BFL_OTP     = 4'h1,
    BFL_REGRST  = 4'h3,
    BFL_TRIM    = 4'h2,
    BFL_SETTLE  = 4'h6,
    BFL_PERSIST = 4'h7,
    BFL_PERIPH  = 4'h5,
    BFL_I2C     = 4'h4,
    BFL_DBCHK   = 4'hC,
    BFL_DBPATH  = 4'hD,
    BFL_HDR     = 4'hF,
    BFL_APP     = 4'hE,
    BFL_RUN     = 4'hA,
    BFL_INVALID = 4'hB
  } bfl_state_t;

  // ****************************************************************
  // Block enables raised at the end of initialization
  // ****************************************************************
  typedef struct packed {
    logic therm;
    logic adc;
    logic crc;
    logic gpio;
    logic intc;
  } bfl_en_t;

  // ****************************************************************
  // Header words as read from flash
  // ****************************************************************
  typedef struct packed {
    logic [31:0] region_pointer;
    logic [31:0] app_code_offset;
  } bfl_hdr_t;

endpackage

// ### bfl_sync.sv
// Two-stage synchronizer for a group of asynchronous levels.
// Assumes the inputs come from pins outside the i_mclk domain.
`timescale 1ns/10ps
module bfl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  // Levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;

  always_comb
  begin
    meta_d = i_d;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule
